// *** hdl/rfr_ctrl.sv ***
`timescale 1ns/1ns
`include "rfr_regs.svh"
module rfr_ctrl #(
	parameter logic [16:0] OVERLOAD_CYC = 17'(`RFR_OVERLOAD_CYC)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_reset_pin_n,
	input wire logic low_supply_lockout,
	input wire logic [1:0] enable_pins,
	input wire logic light_load,
	input wire logic [1:0] load_phases,
	input wire logic out_below_thr,
	input wire logic out_in_window,
	input wire logic peak_limit_raw,
	input wire logic hot_warn_raw,
	input wire logic hot_trip_raw,
	input wire logic meas_done,
	input wire logic [8:0] fuse_ctrl,
	input wire logic [7:0] fuse_vset_high,
	input wire logic [7:0] fuse_vset_low,
	output logic rail_enable,
	output logic [7:0] vout_code,
	output logic [2:0] phase_count,
	output logic fixed_switching_mode,
	output logic irq_line_n_o,
	output logic irq_line_n_oe
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	rfr_pkg::rfr_state_t st_reg, st_next;
	logic [4:0] fcnt_reg, fcnt_next;
	logic [8:0] ctrl_reg, ctrl_next;
	logic [7:0] vhigh_reg, vhigh_next, vlow_reg, vlow_next;
	logic [6:0] mask_reg, mask_next;
	rfr_pkg::rfr_flags_t flags_reg, flags_next, flag_set, flag_clr, flag_keep;
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [7:0] waddr_reg, waddr_next, raddr_reg, raddr_next;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic rail_on_reg, rail_on_next, fixed_reg, fixed_next, irq_oe_reg, irq_oe_next;
	logic [7:0] vcur_reg, vcur_next;
	logic [15:0] scnt_reg, scnt_next;
	logic [2:0] phase_reg, phase_next;
	logic [4:0] raw_vec, filt_vec, filt_d_reg;
	logic wr_fire, soft_cmd, held_in, pin_lvl, rail_want, ramp_active, pending, pg_live;
	logic [7:0] target;
	logic [8:0] wmask;
	logic [2:0] rate;
	logic [15:0] period;

	// ----------------------------------------
	// input filters
	// ----------------------------------------
	assign raw_vec = {out_below_thr & rail_on_reg, out_in_window, hot_trip_raw, hot_warn_raw,
		peak_limit_raw};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_filt
			rfr_filt_if fi_c ();
			assign fi_c.raw = raw_vec[gi];
			assign filt_vec[gi] = fi_c.filt;
			rfr_filter #(
				.COUNT(gi == 4 ? OVERLOAD_CYC : 17'(`RFR_FILT_CYC))
			) u_filter (
				.aclk(aclk),
				.aresetn(aresetn),
				.fi(fi_c)
			);
		end
	endgenerate

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------
	assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;

	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg & ~s_axi_bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg & ~s_axi_rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		raddr_next = raddr_reg;
		if (s_axi_awvalid & awready_reg) begin
			aw_full_next = 1'b1;
			waddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid & wready_reg) begin
			w_full_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (waddr_reg < `RFR_ADDR_LIMIT) ? 2'b00 : 2'b10;
		end
		if (s_axi_arvalid & arready_reg) begin
			rvalid_next = 1'b1;
			raddr_next = s_axi_araddr;
			rresp_next = (s_axi_araddr < `RFR_ADDR_LIMIT) ? 2'b00 : 2'b10;
			unique case ({s_axi_araddr[7:2], 2'b00})
				`RFR_ADDR_CTRL: rdata_next = {23'h00_0000, ctrl_reg};
				`RFR_ADDR_VHIGH: rdata_next = {24'h00_0000, vhigh_reg};
				`RFR_ADDR_VLOW: rdata_next = {24'h00_0000, vlow_reg};
				`RFR_ADDR_FLAGS: rdata_next = {24'h00_0000, flags_reg[`RFR_FLG_OC] |
					flags_reg[`RFR_FLG_SC] | flags_reg[`RFR_FLG_PG], flags_reg};
				`RFR_ADDR_MASK: rdata_next = {25'h000_0000, mask_reg};
				`RFR_ADDR_STATUS: rdata_next = {19'h0_0000, phase_reg, fixed_reg, ramp_active,
					rail_on_reg, 2'b00, pg_live, filt_vec[2], filt_vec[1], 1'b0, filt_vec[0]};
				`RFR_ADDR_VOUT: rdata_next = {24'h00_0000, vcur_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
		awready_next = ~aw_full_next;
		wready_next = ~w_full_next;
		arready_next = ~rvalid_next;
	end

	// bus state is reset only by aresetn
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'b00;
			rvalid_reg <= 1'b0;
			rresp_reg <= 2'b00;
			rdata_reg <= 32'h0000_0000;
			raddr_reg <= 8'h00;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			raddr_reg <= raddr_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
		end
	end

	// ----------------------------------------
	// reset sequencing, registers and flags
	// ----------------------------------------
	assign held_in = ~ext_reset_pin_n | low_supply_lockout;
	assign wmask = {wstrb_reg[1], {8{wstrb_reg[0]}}};
	// soft reset command is a write pulse, never stored
	assign soft_cmd = wr_fire & (waddr_reg == `RFR_ADDR_RESET) & wstrb_reg[0] &
		wdata_reg[`RFR_RESET_CMD] & (st_reg == rfr_pkg::st_run);
	assign pg_live = filt_vec[3] & rail_on_reg;
	assign flag_set = {1'b0, meas_done, filt_vec[3] & ~filt_d_reg[3] & rail_on_reg,
		filt_vec[2] & ~filt_d_reg[2], filt_vec[1] & ~filt_d_reg[1],
		filt_vec[4] & ~filt_d_reg[4], filt_vec[0] & ~filt_d_reg[0]};
	assign flag_clr = (wr_fire & (waddr_reg == `RFR_ADDR_FLAGS) & wstrb_reg[0]) ?
		wdata_reg[6:0] : 7'h00;
	assign flag_keep = {3'b000, filt_vec[2], filt_vec[1], 1'b0, filt_vec[0]};

	always_comb begin
		st_next = st_reg;
		fcnt_next = fcnt_reg;
		ctrl_next = ctrl_reg;
		vhigh_next = vhigh_reg;
		vlow_next = vlow_reg;
		mask_next = mask_reg;
		// write one clears, but not OC, HW or HT while still active; set wins over clear
		flags_next = (flags_reg & ~(flag_clr & ~flag_keep)) | flag_set;
		if (held_in) begin
			st_next = rfr_pkg::st_held;
			fcnt_next = 5'h00;
			ctrl_next = `RFR_CTRL_RST;
			vhigh_next = `RFR_VSET_RST;
			vlow_next = `RFR_VSET_RST;
			mask_next = `RFR_MASK_RST;
			flags_next = `RFR_FLAGS_RST;
		end else begin
			unique case (st_reg)
				rfr_pkg::st_held: begin
					st_next = rfr_pkg::st_fuse;
					fcnt_next = 5'h00;
				end
				rfr_pkg::st_fuse: begin
					if (fcnt_reg == `RFR_FUSE_LOAD_CYC - 5'h01) begin
						st_next = rfr_pkg::st_run;
						ctrl_next = fuse_ctrl;
						vhigh_next = fuse_vset_high;
						vlow_next = fuse_vset_low;
						flags_next[`RFR_FLG_RST] = 1'b1;
					end else begin
						fcnt_next = fcnt_reg + 5'h01;
					end
				end
				rfr_pkg::st_run: begin
					if (soft_cmd) begin
						// soft reset defaults and reloads fuses
						st_next = rfr_pkg::st_fuse;
						fcnt_next = 5'h00;
						ctrl_next = `RFR_CTRL_RST;
						vhigh_next = `RFR_VSET_RST;
						vlow_next = `RFR_VSET_RST;
						mask_next = `RFR_MASK_RST;
						flags_next = `RFR_FLAGS_RST;
					end else if (wr_fire) begin
						if (waddr_reg == `RFR_ADDR_CTRL) begin
							ctrl_next = (ctrl_reg & ~wmask) | (wdata_reg[8:0] & wmask);
						end
						if (waddr_reg == `RFR_ADDR_VHIGH && wstrb_reg[0]) begin
							vhigh_next = wdata_reg[7:0];
						end
						if (waddr_reg == `RFR_ADDR_VLOW && wstrb_reg[0]) begin
							vlow_next = wdata_reg[7:0];
						end
						if (waddr_reg == `RFR_ADDR_MASK && wstrb_reg[0]) begin
							mask_next = wdata_reg[6:0] & `RFR_MASKABLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= rfr_pkg::st_held;
			fcnt_reg <= 5'h00;
			ctrl_reg <= `RFR_CTRL_RST;
			vhigh_reg <= `RFR_VSET_RST;
			vlow_reg <= `RFR_VSET_RST;
			mask_reg <= `RFR_MASK_RST;
			flags_reg <= `RFR_FLAGS_RST;
			filt_d_reg <= 5'h00;
		end else begin
			st_reg <= st_next;
			fcnt_reg <= fcnt_next;
			ctrl_reg <= ctrl_next;
			vhigh_reg <= vhigh_next;
			vlow_reg <= vlow_next;
			mask_reg <= mask_next;
			flags_reg <= flags_next;
			filt_d_reg <= filt_vec;
		end
	end

	// ----------------------------------------
	// rail enable, ramp and switching mode
	// ----------------------------------------
	assign pin_lvl = enable_pins[ctrl_reg[`RFR_CTRL_PINSEL]];
	assign rail_want = ctrl_reg[`RFR_CTRL_EN] & (~ctrl_reg[`RFR_CTRL_PINCTRL] |
		ctrl_reg[`RFR_CTRL_ROOFFLOOR] | pin_lvl);
	assign target = (ctrl_reg[`RFR_CTRL_PINCTRL] & ctrl_reg[`RFR_CTRL_ROOFFLOOR] & ~pin_lvl) ?
		vlow_reg : vhigh_reg;
	assign rate = ctrl_reg[`RFR_CTRL_RATE_MSB:`RFR_CTRL_RATE_LSB];
	assign period = `RFR_RAMP_SLOW_CYC >> rate;
	assign ramp_active = rail_on_reg & (vcur_reg != target);
	// unmaskable short and trip flags always count
	assign pending = |(flags_reg & ~(mask_reg & `RFR_MASKABLE));

	always_comb begin
		rail_on_next = (st_next == rfr_pkg::st_run) & rail_want & ~flags_next[`RFR_FLG_SC] &
			~flags_next[`RFR_FLG_HT] & ~filt_vec[2];
		vcur_next = vcur_reg;
		scnt_next = 16'h0000;
		if (!rail_on_reg) begin
			vcur_next = 8'h00;
		end else if (ramp_active) begin
			if (scnt_reg >= period - 16'h0001) begin
				vcur_next = (vcur_reg < target) ? vcur_reg + 8'h01 : vcur_reg - 8'h01;
			end else begin
				scnt_next = scnt_reg + 16'h0001;
			end
		end
		if (!rail_on_reg) begin
			phase_next = 3'h0;
			fixed_next = 1'b0;
		end else if (ramp_active) begin
			fixed_next = 1'b1;
			phase_next = ctrl_reg[`RFR_CTRL_FMP] ? 3'h4 : 3'({1'b0, rate[2:1]} + 3'h1);
		end else begin
			// settled mode from load and force bits
			fixed_next = ctrl_reg[`RFR_CTRL_FFIX] | ctrl_reg[`RFR_CTRL_FMP] | ~light_load;
			phase_next = ctrl_reg[`RFR_CTRL_FMP] ? 3'h4 : 3'({1'b0, load_phases} + 3'h1);
		end
		// line driven low while anything unmasked pending
		irq_oe_next = pending;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rail_on_reg <= 1'b0;
			vcur_reg <= 8'h00;
			scnt_reg <= 16'h0000;
			phase_reg <= 3'h0;
			fixed_reg <= 1'b0;
			irq_oe_reg <= 1'b0;
		end else begin
			rail_on_reg <= rail_on_next;
			vcur_reg <= vcur_next;
			scnt_reg <= scnt_next;
			phase_reg <= phase_next;
			fixed_reg <= fixed_next;
			irq_oe_reg <= irq_oe_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign rail_enable = rail_on_reg;
	assign vout_code = vcur_reg;
	assign phase_count = phase_reg;
	assign fixed_switching_mode = fixed_reg;
	assign irq_line_n_o = 1'b0;
	assign irq_line_n_oe = irq_oe_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_ramp_step_size: assert property (rail_on_reg && $past(rail_on_reg) |->
		vcur_reg == $past(vcur_reg) || vcur_reg == $past(vcur_reg) + 8'h01 ||
		vcur_reg == $past(vcur_reg) - 8'h01) else $error("ramp stepped by more than one");
	chk_ramp_fixed_mode: assert property (ramp_active |=> fixed_reg)
		else $error("ramp without fixed switching");
	chk_ramp_all_phases: assert property (ramp_active && ctrl_reg[`RFR_CTRL_FMP]
		|=> phase_reg == 3'h4) else $error("forced multiphase ramp lacks phases");
	chk_soft_reads_zero: assert property ($rose(rvalid_reg) &&
		{raddr_reg[7:2], 2'b00} == `RFR_ADDR_RESET |-> rdata_reg == 32'h0000_0000)
		else $error("soft reset bit read back set");
	chk_soft_rail_off: assert property (soft_cmd |=> !rail_on_reg &&
		ctrl_reg == `RFR_CTRL_RST ##[1:20] st_reg == rfr_pkg::st_run)
		else $error("soft reset sequence wrong");
	chk_bus_survives: assert property (bvalid_reg && !s_axi_bready |=> bvalid_reg)
		else $error("write response dropped");
	chk_pin_reset: assert property (held_in |=> !rail_on_reg && flags_reg == 7'h00 &&
		st_reg == rfr_pkg::st_held) else $error("reset pin did not hold defaults");
	chk_reset_flag: assert property ($fell(st_reg == rfr_pkg::st_fuse) &&
		st_reg == rfr_pkg::st_run |-> flags_reg[`RFR_FLG_RST]) else $error("reset flag missing");
	chk_irq_follow: assert property (pending |=> irq_oe_reg)
		else $error("interrupt line not asserted");
	chk_irq_release: assert property (!pending |=> !irq_oe_reg)
		else $error("interrupt line not released");
	chk_oc_clear_block: assert property (filt_vec[0] && flags_reg[`RFR_FLG_OC]
		|=> flags_reg[`RFR_FLG_OC] || $past(held_in) || $past(soft_cmd))
		else $error("overcurrent flag cleared while active");
	chk_short_rail_off: assert property (flags_reg[`RFR_FLG_SC] |-> !rail_on_reg)
		else $error("rail on with short fault");
	chk_trip_rail_off: assert property (filt_vec[2] |=> !rail_on_reg)
		else $error("rail on while hot trip");
	chk_mask_records: assert property (flag_set[`RFR_FLG_MR] && !held_in &&
		!soft_cmd && st_reg == rfr_pkg::st_run |=> flags_reg[`RFR_FLG_MR])
		else $error("masked flag not recorded");

	cov_ramp_done: cover property (ramp_active ##1 !ramp_active && rail_on_reg);
	cov_soft_reset: cover property (soft_cmd);
	cov_short_fault: cover property ($rose(flags_reg[`RFR_FLG_SC]));
	cov_irq_cycle: cover property ($rose(irq_oe_reg) ##[1:50] $fell(irq_oe_reg));
endmodule : rfr_ctrl

// *** hdl/rfr_filt_if.sv ***
`timescale 1ns/1ns
interface rfr_filt_if;
	logic raw;
	logic filt;
	modport filt_side (input raw, output filt);
	modport user_side (output raw, input filt);
endinterface : rfr_filt_if

// *** hdl/rfr_filter.sv ***
`timescale 1ns/1ns
module rfr_filter #(
	parameter logic [16:0] COUNT = 17'h0_0001
) (
	input wire logic aclk,
	input wire logic aresetn,
	rfr_filt_if.filt_side fi
);
	logic [16:0] cnt_reg;
	logic [16:0] cnt_next;
	logic filt_reg;
	logic filt_next;

	// ----------------------------------------
	// debounce: follow raw after COUNT steady cycles
	// ----------------------------------------
	always_comb begin
		filt_next = filt_reg;
		cnt_next = 17'h0_0000;
		if (fi.raw != filt_reg) begin
			if (cnt_reg >= COUNT - 17'h0_0001) begin
				filt_next = fi.raw;
			end else begin
				cnt_next = cnt_reg + 17'h0_0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 17'h0_0000;
			filt_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			filt_reg <= filt_next;
		end
	end

	assign fi.filt = filt_reg;

	chk_filter_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(filt_reg) |-> filt_reg == $past(fi.raw))
		else $error("filtered level changed against raw");
endmodule : rfr_filter

// *** hdl/rfr_pkg.sv ***
package rfr_pkg;
	typedef enum logic [1:0] {st_held, st_fuse, st_run} rfr_state_t;
	typedef logic [6:0] rfr_flags_t;
endpackage : rfr_pkg

// *** hdl/rfr_regs.svh ***
`ifndef RFR_REGS_SVH
`define RFR_REGS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define RFR_ADDR_CTRL 8'h00
`define RFR_ADDR_VHIGH 8'h04
`define RFR_ADDR_VLOW 8'h08
`define RFR_ADDR_RESET 8'h0C
`define RFR_ADDR_FLAGS 8'h10
`define RFR_ADDR_MASK 8'h14
`define RFR_ADDR_STATUS 8'h18
`define RFR_ADDR_VOUT 8'h1C
`define RFR_ADDR_LIMIT 8'h20

// ----------------------------------------
// control field positions
// ----------------------------------------
`define RFR_CTRL_EN 0
`define RFR_CTRL_PINCTRL 1
`define RFR_CTRL_ROOFFLOOR 2
`define RFR_CTRL_PINSEL 3
`define RFR_CTRL_FFIX 4
`define RFR_CTRL_FMP 5
`define RFR_CTRL_RATE_LSB 6
`define RFR_CTRL_RATE_MSB 8
`define RFR_RESET_CMD 0

// ----------------------------------------
// flag field positions
// ----------------------------------------
`define RFR_FLG_OC 0
`define RFR_FLG_SC 1
`define RFR_FLG_HW 2
`define RFR_FLG_HT 3
`define RFR_FLG_PG 4
`define RFR_FLG_MR 5
`define RFR_FLG_RST 6
`define RFR_MASKABLE 7'h75

// ----------------------------------------
// reset values
// ----------------------------------------
`define RFR_CTRL_RST 9'h000
`define RFR_VSET_RST 8'h00
`define RFR_MASK_RST 7'h00
`define RFR_FLAGS_RST 7'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define RFR_CLK_MHZ 100
`define RFR_FILT_US 20
`define RFR_FILT_CYC (`RFR_FILT_US * `RFR_CLK_MHZ)
`define RFR_OVERLOAD_MS 1
`define RFR_OVERLOAD_CYC (`RFR_OVERLOAD_MS * 1000 * `RFR_CLK_MHZ)
`define RFR_FUSE_LOAD_CYC 5'h10
`define RFR_RAMP_SLOW_CYC 16'h0500

`endif

// *** sim/regulator_fault_reset_irq_tb_top.sv ***
`timescale 1ns/1ns
`include "rfr_regs.svh"
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module regulator_fault_reset_irq_tb_top;
	logic aclk, aresetn, ext_reset_pin_n, low_supply_lockout, light_load, out_below_thr;
	logic hot_warn_raw, meas_done, peak_limit_raw, hot_trip_raw, out_in_window, irq_o;
	logic [1:0] enable_pins, bresp, rresp;
	logic [7:0] awaddr, araddr, vout_code, fuse_hi;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic rail_enable, fixed_switching_mode, irq_line_n_oe;
	logic [2:0] phase_count;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	rfr_host_model host_u (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	rfr_ctrl #(.OVERLOAD_CYC(17'h0_0032)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_reset_pin_n(ext_reset_pin_n),
		.low_supply_lockout(low_supply_lockout), .enable_pins(enable_pins),
		.light_load(light_load), .load_phases(2'h0), .out_below_thr(out_below_thr),
		.out_in_window(out_in_window), .peak_limit_raw(peak_limit_raw),
		.hot_warn_raw(hot_warn_raw), .hot_trip_raw(hot_trip_raw), .meas_done(meas_done),
		.fuse_ctrl(9'h000), .fuse_vset_high(fuse_hi), .fuse_vset_low(8'h00),
		.rail_enable(rail_enable), .vout_code(vout_code), .phase_count(phase_count),
		.fixed_switching_mode(fixed_switching_mode), .irq_line_n_o(irq_o),
		.irq_line_n_oe(irq_line_n_oe));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [1:0] bresp_l;
	task automatic w(input logic [7:0] a, input logic [31:0] v);
		host_u.wr(a, v, bresp_l);
	endtask : w
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		host_u.rd(a, d);
		`CHK("read", e, d & m)
	endtask : rc
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc_wait
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			conclude();
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{aresetn, low_supply_lockout, light_load, out_below_thr, hot_warn_raw, meas_done} = '0;
		{peak_limit_raw, hot_trip_raw, out_in_window} = '0;
		fuse_hi = 8'h5A;
		ext_reset_pin_n = 1'b1;
		enable_pins = 2'h0;
		cyc_wait(10);
		aresetn <= 1'b1;
		light_load <= 1'b1;
		cyc_wait(30);
		rc(`RFR_ADDR_FLAGS, 32'hffff_ffff, 32'h0000_0040);
		rc(`RFR_ADDR_VHIGH, 32'hffff_ffff, 32'h0000_005a);
		`CHK("irq", 1'b1, irq_line_n_oe)
		`CHK("irq_o", 1'b0, irq_o)
		w(`RFR_ADDR_FLAGS, 32'h0000_0040);
		cyc_wait(2);
		`CHK("irq", 1'b0, irq_line_n_oe)
		host_u.wr(8'h24, 32'h0000_0000, bresp_l);
		`CHK("bresp", 2'h2, bresp_l)
		rc(8'h24, 32'hffff_ffff, 32'h0000_0000);
		`CHK("rresp", 2'h2, rresp)
		$display("test reset flag done");
		w(`RFR_ADDR_MASK, 32'h0000_0020);
		meas_done <= 1'b1;
		@(posedge aclk);
		meas_done <= 1'b0;
		cyc_wait(3);
		`CHK("irq", 1'b0, irq_line_n_oe)
		rc(`RFR_ADDR_FLAGS, 32'hffff_ffff, 32'h0000_0020);
		w(`RFR_ADDR_FLAGS, 32'h0000_0020);
		rc(`RFR_ADDR_FLAGS, 32'hffff_ffff, 32'h0000_0000);
		$display("test mask done");
		hot_warn_raw <= 1'b1;
		cyc_wait(2010);
		rc(`RFR_ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
		`CHK("irq", 1'b1, irq_line_n_oe)
		w(`RFR_ADDR_FLAGS, 32'h0000_0004);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0004, 32'h0000_0004);
		hot_warn_raw <= 1'b0;
		cyc_wait(2010);
		w(`RFR_ADDR_FLAGS, 32'h0000_0004);
		rc(`RFR_ADDR_FLAGS, 32'hffff_ffff, 32'h0000_0000);
		$display("test warning done");
		w(`RFR_ADDR_VHIGH, 32'h0000_0003);
		w(`RFR_ADDR_CTRL, 32'h0000_0141);
		cyc_wait(30);
		`CHK("fixed", 1'b1, fixed_switching_mode)
		`CHK("phases", 3'h3, phase_count)
		cyc_wait(150);
		`CHK("vout", 8'h03, vout_code)
		`CHK("fixed", 1'b0, fixed_switching_mode)
		w(`RFR_ADDR_VHIGH, 32'h0000_0006);
		w(`RFR_ADDR_CTRL, 32'h0000_0161);
		cyc_wait(30);
		`CHK("phases", 3'h4, phase_count)
		$display("test ramp done");
		peak_limit_raw <= 1'b1;
		out_in_window <= 1'b1;
		cyc_wait(2010);
		`CHK("rail", 1'b1, rail_enable)
		rc(`RFR_ADDR_FLAGS, 32'h0000_0091, 32'h0000_0091);
		rc(`RFR_ADDR_STATUS, 32'h0000_0011, 32'h0000_0011);
		w(`RFR_ADDR_FLAGS, 32'h0000_0011);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0011, 32'h0000_0001);
		peak_limit_raw <= 1'b0;
		out_in_window <= 1'b0;
		cyc_wait(2010);
		w(`RFR_ADDR_FLAGS, 32'h0000_0001);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0091, 32'h0000_0000);
		$display("test limit and power good done");
		out_below_thr <= 1'b1;
		cyc_wait(60);
		`CHK("rail", 1'b0, rail_enable)
		rc(`RFR_ADDR_FLAGS, 32'h0000_0082, 32'h0000_0082);
		out_below_thr <= 1'b0;
		w(`RFR_ADDR_FLAGS, 32'h0000_0002);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0082, 32'h0000_0000);
		$display("test overload done");
		hot_trip_raw <= 1'b1;
		cyc_wait(2010);
		`CHK("rail", 1'b0, rail_enable)
		rc(`RFR_ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
		w(`RFR_ADDR_FLAGS, 32'h0000_0008);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0008, 32'h0000_0008);
		hot_trip_raw <= 1'b0;
		cyc_wait(2010);
		w(`RFR_ADDR_FLAGS, 32'h0000_0008);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0008, 32'h0000_0000);
		$display("test thermal trip done");
		w(`RFR_ADDR_CTRL, 32'h0000_0141);
		cyc_wait(5);
		`CHK("rail", 1'b1, rail_enable)
		w(`RFR_ADDR_RESET, 32'h0000_0001);
		`CHK("rail", 1'b0, rail_enable)
		rc(`RFR_ADDR_RESET, 32'hffff_ffff, 32'h0000_0000);
		cyc_wait(30);
		rc(`RFR_ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
		rc(`RFR_ADDR_VHIGH, 32'hffff_ffff, 32'h0000_005a);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0040, 32'h0000_0040);
		$display("test soft reset done");
		w(`RFR_ADDR_MASK, 32'h0000_0020);
		ext_reset_pin_n <= 1'b0;
		cyc_wait(2);
		ext_reset_pin_n <= 1'b1;
		cyc_wait(30);
		rc(`RFR_ADDR_MASK, 32'hffff_ffff, 32'h0000_0000);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0040, 32'h0000_0040);
		$display("test pin reset done");
		w(`RFR_ADDR_FLAGS, 32'h0000_0040);
		w(`RFR_ADDR_CTRL, 32'h0000_0001);
		cyc_wait(2);
		`CHK("rail", 1'b1, rail_enable)
		low_supply_lockout <= 1'b1;
		cyc_wait(2);
		`CHK("rail", 1'b0, rail_enable)
		low_supply_lockout <= 1'b0;
		cyc_wait(30);
		rc(`RFR_ADDR_FLAGS, 32'h0000_0040, 32'h0000_0040);
		rc(`RFR_ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
		$display("test lockout done");
		w(`RFR_ADDR_VLOW, 32'h0000_0002);
		w(`RFR_ADDR_VHIGH, 32'h0000_0004);
		w(`RFR_ADDR_CTRL, 32'h0000_01c7);
		cyc_wait(40);
		`CHK("vout", 8'h02, vout_code)
		enable_pins <= 2'h1;
		cyc_wait(40);
		`CHK("vout", 8'h04, vout_code)
		$display("test pin select done");
		conclude();
	end
endmodule : regulator_fault_reset_irq_tb_top

// *** sim/rfr_host_model.sv ***
`timescale 1ns/1ns
module rfr_host_model (
	input wire logic aclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// ----------------------------------------
	// one write, address and data offered together
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	// ----------------------------------------
	// one read
	// ----------------------------------------
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : rfr_host_model
